// ### hw/atp_lut_mem.sv
/*
  256-entry colour lookup table: one write port, two registered reads.
  assumes: single clock, ce freezes everything, contents power up unknown.
*/
`timescale 1ns/10ps
`default_nettype none

module atp_lut_mem (
  // clock and control
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // write port
  input wire logic we_i,
  input wire logic [7:0] waddr_i,
  input wire atp_pkg::atp_rgb_t wdata_i,
  // host read port
  input wire logic [7:0] raddr_a_i,
  output var atp_pkg::atp_rgb_t rdata_a_o,
  // video read port
  input wire logic [7:0] raddr_b_i,
  output var atp_pkg::atp_rgb_t rdata_b_o
);
  import atp_pkg::*;

  atp_rgb_t mem_r [256]; // table storage, no reset

  // table write
  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  // registered reads
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_a_o <= '0;
      rdata_b_o <= '0;
    end else if (ce_i) begin
      rdata_a_o <= mem_r[raddr_a_i];
      rdata_b_o <= mem_r[raddr_b_i];
    end
  end

endmodule : atp_lut_mem

`default_nettype wire

// ### hw/atp_map.svh
/*
  address, index, field and reset constants of the attribute tail and
  palette access port.
  assumes: included by bare name from the package and the modules.
*/
`ifndef ATP_MAP_SVH
`define ATP_MAP_SVH

// byte i/o ports (10-bit decode)
`define ATP_PORT_ATTR_WR 10'h3c0
`define ATP_PORT_ATTR_RD 10'h3c1
`define ATP_PORT_MASK 10'h3c6
`define ATP_PORT_RPTR 10'h3c7
`define ATP_PORT_WPTR 10'h3c8
`define ATP_PORT_DATA 10'h3c9
`define ATP_PORT_STAT1_MONO 10'h3ba
`define ATP_PORT_STAT1_COL 10'h3da

// attribute indices held here
`define ATP_IDX_BORDER 5'h11
`define ATP_IDX_PLANE 5'h12
`define ATP_IDX_PAN 5'h13
`define ATP_IDX_HCS 5'h14

// reset values
`define ATP_RST_BYTE 8'h00
`define ATP_RST_MASK 8'hff
`define ATP_RST_IDX 6'h00
`define ATP_RST_PTR 8'h00

// writable bits, reserved bits read zero
`define ATP_WMASK_PLANE 8'h3f
`define ATP_WMASK_PAN 8'h0f
`define ATP_WMASK_HCS 8'h0f

// field positions
`define ATP_IDX_PASS_B 5
`define ATP_IDX_ADDR_F 4:0
`define ATP_PLANE_EN_F 3:0
`define ATP_STMUX_F 5:4
`define ATP_PAN_F 3:0
`define ATP_SC76_F 3:2
`define ATP_SC54_F 1:0

// status mux selections
`define ATP_STMUX_20 2'b00
`define ATP_STMUX_54 2'b01
`define ATP_STMUX_31 2'b10

// dac drive and palette status codes
`define ATP_DRV_IDLE 2'b00
`define ATP_DRV_PTR 2'b11
`define ATP_DRV_DATA 2'b01
`define ATP_STAT_WR 2'b00
`define ATP_STAT_RD 2'b11

// panning codes
`define ATP_PAN_9DOT_ZERO 4'h8
`define ATP_PAN_8DOT_MAX 4'h7
`define ATP_PAN_ZERO 4'h0
`define ATP_PAN_ONE 4'h1

`endif

// ### hw/atp_pkg.sv
/*
  types of the attribute tail and palette access port.
  assumes: atp_map.svh on the include path.
*/
`include "atp_map.svh"

package atp_pkg;

  // position within a red, green, blue byte sequence
  typedef enum logic [1:0] {
    seq_red = 2'b00,
    seq_grn = 2'b01,
    seq_blu = 2'b11
  } atp_seq_t;

  // one lookup-table entry
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } atp_rgb_t;

  // host byte i/o request, strobes one cycle wide
  typedef struct packed {
    logic [9:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } atp_io_req_t;

  // video side inputs from the rest of the pipeline
  typedef struct packed {
    logic [3:0] plane_pix;
    logic [5:0] pal_vid;
    logic [7:0] pix256;
    logic active;
    logic mode_256;
    logic mode_9dot;
    logic cs_sel;
  } atp_vid_in_t;

  // whole state of the top module
  typedef struct packed {
    logic attr_data_sel;
    logic [5:0] attr_idx;
    logic [7:0] border;
    logic [7:0] plane;
    logic [7:0] pan;
    logic [7:0] hcs;
    logic [7:0] mask;
    logic [7:0] rd_ptr;
    logic [7:0] wr_ptr;
    logic rd_mode;
    atp_seq_t seq;
    logic [7:0] red;
    logic [7:0] grn;
    logic [1:0] drive;
    logic [7:0] rdata;
    logic rvalid;
    logic [3:0] plane_pix;
    logic [7:0] colour;
    logic blank;
    logic blank_q;
    atp_rgb_t rgb;
    logic [3:0] pan_shift;
    logic [1:0] stat_vid;
  } atp_state_t;

endpackage : atp_pkg

// ### hw/atp_top.sv
/*
  attribute tail registers (border, plane enable, panning, colour select)
  and the palette lookup-table access port, with the colour path.
  assumes: host strobes are one cycle, synchronous, at least one idle
  cycle between requests; crt lock bit comes from the crt controller.
*/
// Functional notes
// - border writes ignored while crt lock set
// - border value is the overscan colour
// - cleared plane bit forces pixel bit zero
// - status mux picks colour outputs for bits
// - pan field shifts display left by pixels
// - nine-dot and eight-dot pan code mapping
// - 256-colour pan uses codes 0,2,4,6 only
// - high colour select gives dac bits 7:6
// - mode select substitutes low select for 5:4
// - write index then three bytes commit entry
// - write pointer advances after each commit
// - read index then three reads give rgb
// - pixel mask zero bits ignored in lookup
// - palette status 00 writing, 11 reading
// - pointer writes drive 11 onto dac status
// - data port access drives 01 onto status
// - 256 entries, addressed by active pointer
// - 3c7 read pointer write, status read
// - attribute index/data toggle flips on writes
// - input status 1 read resets toggle
// - palette source zero blanks video output
`timescale 1ns/10ps
`default_nettype none
`include "atp_map.svh"

module atp_top (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // host byte i/o
  input wire atp_pkg::atp_io_req_t io_req_i,
  output logic [7:0] io_rdata_o,
  output logic io_rvalid_o,
  // crt controller lock bit
  input wire logic crt_lock_i,
  // video pipeline
  input wire atp_pkg::atp_vid_in_t vid_i,
  output logic [3:0] plane_pix_o,
  output logic [7:0] colour_o,
  output var atp_pkg::atp_rgb_t rgb_o,
  output logic video_blank_o,
  output logic [3:0] pan_shift_o,
  output logic [1:0] dac_drive_o
);
  import atp_pkg::*;

  atp_state_t st_r; // registered state
  atp_state_t st_nxt; // next state
  atp_rgb_t hdat; // entry at read pointer
  atp_rgb_t vdat; // entry for current colour
  logic lut_we; // commit strobe
  atp_rgb_t lut_wdata; // committed entry
  logic [7:0] vid_addr; // masked lookup index

  // decoded host accesses
  logic wr_attr, rd_attr_idx, rd_attr_dat, rd_stat1;
  logic wr_mask, rd_mask, wr_rptr, rd_pstat, wr_wptr, rd_wptr;
  logic wr_data, rd_data;

  // address decode
  always_comb begin
    wr_attr = 1'b0;
    rd_attr_idx = 1'b0;
    rd_attr_dat = 1'b0;
    rd_stat1 = 1'b0;
    wr_mask = 1'b0;
    rd_mask = 1'b0;
    wr_rptr = 1'b0;
    rd_pstat = 1'b0;
    wr_wptr = 1'b0;
    rd_wptr = 1'b0;
    wr_data = 1'b0;
    rd_data = 1'b0;
    if (io_req_i.addr == `ATP_PORT_ATTR_WR) begin
      wr_attr = io_req_i.wr;
      rd_attr_idx = io_req_i.rd;
    end else if (io_req_i.addr == `ATP_PORT_ATTR_RD) begin
      rd_attr_dat = io_req_i.rd;
    end else if (io_req_i.addr == `ATP_PORT_STAT1_MONO ||
                 io_req_i.addr == `ATP_PORT_STAT1_COL) begin
      rd_stat1 = io_req_i.rd;
    end else if (io_req_i.addr == `ATP_PORT_MASK) begin
      wr_mask = io_req_i.wr;
      rd_mask = io_req_i.rd;
    end else if (io_req_i.addr == `ATP_PORT_RPTR) begin
      wr_rptr = io_req_i.wr;
      rd_pstat = io_req_i.rd;
    end else if (io_req_i.addr == `ATP_PORT_WPTR) begin
      wr_wptr = io_req_i.wr;
      rd_wptr = io_req_i.rd;
    end else if (io_req_i.addr == `ATP_PORT_DATA) begin
      wr_data = io_req_i.wr;
      rd_data = io_req_i.rd;
    end
  end

  // commit on the third byte of a write sequence
  always_comb begin
    lut_we = ce_i && wr_data && !st_r.rd_mode
             && st_r.seq == seq_blu;
    lut_wdata = '{r: st_r.red, g: st_r.grn, b: io_req_i.wdata};
    vid_addr = st_r.colour & st_r.mask;
  end

  // lookup table
  atp_lut_mem u_lut (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .we_i(lut_we),
    .waddr_i(st_r.wr_ptr),
    .wdata_i(lut_wdata),
    .raddr_a_i(st_r.rd_ptr),
    .rdata_a_o(hdat),
    .raddr_b_i(vid_addr),
    .rdata_b_o(vdat)
  );

  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    // host side
    if (wr_attr) begin
      st_nxt.attr_data_sel = !st_r.attr_data_sel;
      if (!st_r.attr_data_sel) begin
        st_nxt.attr_idx = io_req_i.wdata[5:0];
      end else if (st_r.attr_idx[`ATP_IDX_ADDR_F] == `ATP_IDX_BORDER) begin
        if (!crt_lock_i) begin
          st_nxt.border = io_req_i.wdata;
        end
      end else if (st_r.attr_idx[`ATP_IDX_ADDR_F] == `ATP_IDX_PLANE) begin
        st_nxt.plane = io_req_i.wdata & `ATP_WMASK_PLANE;
      end else if (st_r.attr_idx[`ATP_IDX_ADDR_F] == `ATP_IDX_PAN) begin
        st_nxt.pan = io_req_i.wdata & `ATP_WMASK_PAN;
      end else if (st_r.attr_idx[`ATP_IDX_ADDR_F] == `ATP_IDX_HCS) begin
        st_nxt.hcs = io_req_i.wdata & `ATP_WMASK_HCS;
      end
    end
    if (rd_stat1) begin
      st_nxt.attr_data_sel = 1'b0;
    end
    if (wr_mask) begin
      st_nxt.mask = io_req_i.wdata;
    end
    // pointer writes open a sequence
    if (wr_rptr || wr_wptr) begin
      st_nxt.seq = seq_red;
      st_nxt.drive = `ATP_DRV_PTR;
      st_nxt.rd_mode = wr_rptr;
      if (wr_rptr) begin
        st_nxt.rd_ptr = io_req_i.wdata;
      end else begin
        st_nxt.wr_ptr = io_req_i.wdata;
      end
    end
    // data port accesses
    if (wr_data || rd_data) begin
      st_nxt.drive = `ATP_DRV_DATA;
    end
    if (wr_data && !st_r.rd_mode) begin
      case (st_r.seq)
        seq_red: begin
          st_nxt.red = io_req_i.wdata;
          st_nxt.seq = seq_grn;
        end
        seq_grn: begin
          st_nxt.grn = io_req_i.wdata;
          st_nxt.seq = seq_blu;
        end
        default: begin
          st_nxt.seq = seq_red;
          st_nxt.wr_ptr = 8'(st_r.wr_ptr + 8'h01);
        end
      endcase
    end
    if (rd_data && st_r.rd_mode) begin
      case (st_r.seq)
        seq_red: st_nxt.seq = seq_grn;
        seq_grn: st_nxt.seq = seq_blu;
        default: begin
          st_nxt.seq = seq_red;
          st_nxt.rd_ptr = 8'(st_r.rd_ptr + 8'h01);
        end
      endcase
    end
    // read answer
    if (io_req_i.rd) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = `ATP_RST_BYTE;
      if (rd_attr_idx) begin
        st_nxt.rdata = {2'b00, st_r.attr_idx};
      end else if (rd_attr_dat) begin
        if (st_r.attr_idx[`ATP_IDX_ADDR_F] == `ATP_IDX_BORDER) begin
          st_nxt.rdata = st_r.border;
        end else if (st_r.attr_idx[`ATP_IDX_ADDR_F] == `ATP_IDX_PLANE) begin
          st_nxt.rdata = st_r.plane;
        end else if (st_r.attr_idx[`ATP_IDX_ADDR_F] == `ATP_IDX_PAN) begin
          st_nxt.rdata = st_r.pan;
        end else if (st_r.attr_idx[`ATP_IDX_ADDR_F] == `ATP_IDX_HCS) begin
          st_nxt.rdata = st_r.hcs;
        end
      end else if (rd_stat1) begin
        st_nxt.rdata[`ATP_STMUX_F] = st_r.stat_vid;
      end else if (rd_mask) begin
        st_nxt.rdata = st_r.mask;
      end else if (rd_pstat) begin
        st_nxt.rdata[1:0] = st_r.rd_mode ? `ATP_STAT_RD
                                         : `ATP_STAT_WR;
      end else if (rd_wptr) begin
        st_nxt.rdata = st_r.wr_ptr;
      end else if (rd_data && st_r.rd_mode) begin
        case (st_r.seq)
          seq_red: st_nxt.rdata = hdat.r;
          seq_grn: st_nxt.rdata = hdat.g;
          default: st_nxt.rdata = hdat.b;
        endcase
      end
    end
    // video side: plane gating
    st_nxt.plane_pix = vid_i.plane_pix & st_r.plane[`ATP_PLANE_EN_F];
    // colour value for the dac
    st_nxt.blank = !st_r.attr_idx[`ATP_IDX_PASS_B];
    if (!st_r.attr_idx[`ATP_IDX_PASS_B]) begin
      st_nxt.colour = `ATP_RST_BYTE;
    end else if (!vid_i.active) begin
      st_nxt.colour = st_r.border;
    end else if (vid_i.mode_256) begin
      st_nxt.colour = vid_i.pix256;
    end else begin
      st_nxt.colour[7:6] = st_r.hcs[`ATP_SC76_F];
      st_nxt.colour[5:4] = vid_i.cs_sel ? st_r.hcs[`ATP_SC54_F]
                                        : vid_i.pal_vid[5:4];
      st_nxt.colour[3:0] = vid_i.pal_vid[3:0];
    end
    st_nxt.blank_q = st_r.blank;
    st_nxt.rgb = st_r.blank_q ? '0 : vdat;
    // status readback mux
    case (st_r.plane[`ATP_STMUX_F])
      `ATP_STMUX_20: st_nxt.stat_vid = {st_r.colour[2], st_r.colour[0]};
      `ATP_STMUX_54: st_nxt.stat_vid = {st_r.colour[5], st_r.colour[4]};
      `ATP_STMUX_31: st_nxt.stat_vid = {st_r.colour[3], st_r.colour[1]};
      default: st_nxt.stat_vid = {st_r.colour[7], st_r.colour[7]};
    endcase
    // panning shift
    if (vid_i.mode_256) begin
      st_nxt.pan_shift = {2'b00, st_r.pan[2:1]};
    end else if (vid_i.mode_9dot) begin
      if (st_r.pan[`ATP_PAN_F] <= `ATP_PAN_8DOT_MAX) begin
        st_nxt.pan_shift = 4'(st_r.pan[`ATP_PAN_F] + `ATP_PAN_ONE);
      end else begin
        st_nxt.pan_shift = `ATP_PAN_ZERO;
      end
    end else if (st_r.pan[`ATP_PAN_F] <= `ATP_PAN_8DOT_MAX) begin
      st_nxt.pan_shift = st_r.pan[`ATP_PAN_F];
    end else begin
      st_nxt.pan_shift = `ATP_PAN_ZERO;
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
      st_r.attr_idx <= `ATP_RST_IDX;
      st_r.border <= `ATP_RST_BYTE;
      st_r.mask <= `ATP_RST_MASK;
      st_r.rd_ptr <= `ATP_RST_PTR;
      st_r.wr_ptr <= `ATP_RST_PTR;
      st_r.seq <= seq_red;
      st_r.drive <= `ATP_DRV_IDLE;
      st_r.blank <= 1'b1;
      st_r.blank_q <= 1'b1;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign io_rdata_o = st_r.rdata;
  assign io_rvalid_o = st_r.rvalid;
  assign plane_pix_o = st_r.plane_pix;
  assign colour_o = st_r.colour;
  assign rgb_o = st_r.rgb;
  assign video_blank_o = st_r.blank;
  assign pan_shift_o = st_r.pan_shift;
  assign dac_drive_o = st_r.drive;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  logic bdr_wr; // border data write
  assign bdr_wr = ce_i && wr_attr && st_r.attr_data_sel
                  && st_r.attr_idx[`ATP_IDX_ADDR_F] == `ATP_IDX_BORDER;

  sequence s_ptr_wr;
    ce_i && (wr_rptr || wr_wptr);
  endsequence
  sequence s_commit;
    lut_we;
  endsequence
  sequence s_blank_run; // source off, then two enabled edges
    ce_i && !st_r.attr_idx[`ATP_IDX_PASS_B] ##1 ce_i [*2];
  endsequence

  a_border_lock: assert property (
    bdr_wr && crt_lock_i |=> $stable(st_r.border))
    else $error("border changed while locked");
  a_overscan_col: assert property (
    ce_i && st_r.attr_idx[`ATP_IDX_PASS_B] && !vid_i.active
    |=> colour_o == $past(st_r.border))
    else $error("overscan colour is not the border value");
  a_plane_gate: assert property (
    ce_i && !st_r.plane[0] |=> !plane_pix_o[0])
    else $error("disabled plane bit passed");
  a_stat_mux7: assert property (
    ce_i && st_r.plane[`ATP_STMUX_F] == 2'b11
    |=> st_r.stat_vid == {2{$past(st_r.colour[7])}})
    else $error("status mux wrong for select 11");
  a_pan_nine: assert property (
    ce_i && vid_i.mode_9dot && !vid_i.mode_256
    && st_r.pan[`ATP_PAN_F] == `ATP_PAN_9DOT_ZERO |=> pan_shift_o == 4'h0)
    else $error("nine-dot code 1000 not zero shift");
  a_dac_high: assert property (
    ce_i && st_r.attr_idx[`ATP_IDX_PASS_B] && vid_i.active
    && !vid_i.mode_256 |=> colour_o[7:6] == $past(st_r.hcs[3:2]))
    else $error("dac high bits not from colour select");
  a_wptr_step: assert property (
    s_commit |=> st_r.wr_ptr == 8'($past(st_r.wr_ptr) + 8'h01)
    ##0 st_r.seq == seq_red)
    else $error("write pointer did not advance after commit");
  a_ptr_drive: assert property (
    s_ptr_wr |=> dac_drive_o == `ATP_DRV_PTR && st_r.seq == seq_red)
    else $error("pointer write did not drive 11");
  a_data_drive: assert property (
    ce_i && (wr_data || rd_data) |=> dac_drive_o == `ATP_DRV_DATA)
    else $error("data access did not drive 01");
  a_pstat_read: assert property (
    ce_i && rd_pstat |=> io_rvalid_o
    && io_rdata_o[1:0] == ($past(st_r.rd_mode) ? 2'b11 : 2'b00))
    else $error("palette status wrong");
  a_toggle_clr: assert property (
    ce_i && rd_stat1 |=> !st_r.attr_data_sel)
    else $error("status read did not reset toggle");
  a_blank_src: assert property (
    ce_i && !st_r.attr_idx[`ATP_IDX_PASS_B] |=> video_blank_o)
    else $error("video not blanked");
  a_blank_rgb: assert property (s_blank_run |=> rgb_o == '0)
    else $error("blanked colour not zero");

endmodule : atp_top

`default_nettype wire

// ### tb/atp_host_model.sv
/*
  host processor model: byte i/o writes and reads toward the device.
  assumes: driven by the bench through its tasks, one caller at a time.
*/
`timescale 1ns/10ps
`default_nettype none

module atp_host_model (
  // clock
  input wire logic clk_i,
  // byte i/o requests toward the device
  output var atp_pkg::atp_io_req_t io_req_o
);
  import atp_pkg::*;

  // idle bus at time zero
  initial begin
    io_req_o = '0;
  end

  // one write strobe, then an idle cycle; data inverted while idle
  task automatic wr(input logic [9:0] addr, input logic [7:0] data);
    @(negedge clk_i);
    io_req_o = '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
    @(negedge clk_i);
    io_req_o.wr = 1'b0;
    io_req_o.wdata = ~data;
    @(negedge clk_i);
  endtask : wr

  // one read strobe, then an idle cycle; address inverted while idle
  task automatic rd(input logic [9:0] addr);
    @(negedge clk_i);
    io_req_o = '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk_i);
    io_req_o.rd = 1'b0;
    io_req_o.addr = ~addr;
    @(negedge clk_i);
  endtask : rd
endmodule : atp_host_model

`default_nettype wire

// ### tb/attribute_tail_and_palette_dac_port_tb.sv
/*
  self-checking bench of the attribute tail and palette port.
  assumes: atp_pkg, atp_map.svh and the host model compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "atp_map.svh"

module attribute_tail_and_palette_dac_port_tb;
  import atp_pkg::*;
  // clock, reset, stimulus
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic crt_lock_i = 1'b0;
  logic ce_i = 1'b1;
  atp_vid_in_t vid_i;
  atp_io_req_t io_req;
  // design outputs
  logic [7:0] io_rdata_o, colour_o;
  logic [3:0] plane_pix_o, pan_shift_o;
  logic [1:0] dac_drive_o;
  logic io_rvalid_o, video_blank_o;
  atp_rgb_t rgb_o;
  // scoreboard, bit 8 marks an answer not compared
  logic [8:0] exp_q[$];
  logic [8:0] n;
  int errors = 0;
  int tests_run = 0;
  integer seed = 32'h9b313dab;
  int i, k, m;
  logic [7:0] b, h, p, idx;
  logic [7:0] pal [0:8];
  logic [7:0] wm [0:3] = '{8'hff, 8'h3f, 8'h0f, 8'h0f};

  // clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  atp_host_model i_host (.clk_i(clk_i), .io_req_o(io_req));

  atp_top i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .io_req_i(io_req), .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o),
    .crt_lock_i(crt_lock_i), .vid_i(vid_i), .plane_pix_o(plane_pix_o),
    .colour_o(colour_o), .rgb_o(rgb_o), .video_blank_o(video_blank_o),
    .pan_shift_o(pan_shift_o), .dac_drive_o(dac_drive_o)
  );

  // one comparison, reported at once on mismatch
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int c);
    repeat (c) @(negedge clk_i);
  endtask : tick

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  // note the answer, then read
  task automatic rdx(input logic [9:0] a, input logic [7:0] e);
    exp_q.push_back({1'b0, e});
    i_host.rd(a);
  endtask : rdx

  // status register 1 read, answer not compared
  task automatic stat_skip();
    exp_q.push_back(9'h100);
    i_host.rd(`ATP_PORT_STAT1_COL);
  endtask : stat_skip

  // indexed attribute write, palette source kept on
  task automatic attr_wr(input logic [4:0] ix, input logic [7:0] d);
    stat_skip();
    i_host.wr(`ATP_PORT_ATTR_WR, {3'b001, ix});
    i_host.wr(`ATP_PORT_ATTR_WR, d);
  endtask : attr_wr

  task automatic attr_rd(input logic [4:0] ix, input logic [7:0] e);
    stat_skip();
    i_host.wr(`ATP_PORT_ATTR_WR, {3'b001, ix});
    rdx(`ATP_PORT_ATTR_RD, e);
  endtask : attr_rd

  // shift per pan code and mode: 0 nine-dot, 1 eight-dot, 2 256-colour
  function automatic logic [3:0] pan_exp(input int md, input logic [3:0] c);
    if (md == 0) return (c < 4'h8) ? c + 4'h1 : 4'h0;
    if (md == 1) return (c < 4'h8) ? c : 4'h0;
    return c >> 1;
  endfunction : pan_exp

  // colour outputs routed to status bits 5 and 4
  function automatic logic [1:0] stat_exp(input logic [1:0] s,
                                          input logic [7:0] c);
    case (s)
      2'b00: return {c[2], c[0]};
      2'b01: return {c[5], c[4]};
      2'b10: return {c[3], c[1]};
      default: return {c[7], c[7]};
    endcase
  endfunction : stat_exp

  // compare each read answer with the oldest note
  always @(negedge clk_i) begin
    if (io_rvalid_o === 1'b1) begin
      n = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h0xx;
      if (!n[8]) chk(io_rdata_o, n[7:0]);
    end
  end

  task end_of_test;
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // watchdog well beyond the expected run
  initial begin
    #400000;
    errors++;
    $display("watchdog expired");
    end_of_test;
  end

  // main sequence
  initial begin
    vid_i = '0;
    vid_i.active = 1'b1;
    tick(5);
    rst_n_i = 1'b1;
    chk(video_blank_o, 1'b1);
    for (k = 0; k < 4; k++) attr_rd(5'h11 + 5'(k), 8'h00);
    rdx(`ATP_PORT_MASK, 8'hff);
    rdx(`ATP_PORT_WPTR, 8'h00);
    done("reset values");
    for (k = 0; k < 4; k++) begin
      b = $random(seed);
      attr_wr(5'h11 + 5'(k), b);
      attr_rd(5'h11 + 5'(k), b & wm[k]);
    end
    attr_wr(`ATP_IDX_BORDER, 8'h96);
    crt_lock_i = 1'b1;
    attr_wr(`ATP_IDX_BORDER, 8'h5a);
    crt_lock_i = 1'b0;
    attr_rd(`ATP_IDX_BORDER, 8'h96);
    i_host.wr(`ATP_PORT_ATTR_WR, 8'h3c);
    attr_rd(`ATP_IDX_BORDER, 8'h3c);
    rdx(`ATP_PORT_ATTR_WR, 8'h31);
    vid_i.active = 1'b0;
    tick(3);
    chk(colour_o, 8'h3c);
    vid_i.active = 1'b1;
    done("attribute registers");
    for (m = 0; m < 3; m++) begin
      vid_i.mode_9dot = (m == 0);
      vid_i.mode_256 = (m == 2);
      for (k = 0; k < ((m == 2) ? 7 : 9); k += (m == 2) ? 2 : 1) begin
        attr_wr(`ATP_IDX_PAN, 8'(k));
        tick(2);
        chk(pan_shift_o, pan_exp(m, 4'(k)));
      end
    end
    vid_i.mode_256 = 1'b0;
    vid_i.mode_9dot = 1'b0;
    done("panning");
    for (k = 0; k < 4; k++) begin
      b = $random(seed);
      p = $random(seed);
      h = $random(seed);
      attr_wr(`ATP_IDX_PLANE, b & 8'h0f);
      attr_wr(`ATP_IDX_HCS, h & 8'h0f);
      vid_i.plane_pix = p[7:4];
      vid_i.pal_vid = p[5:0];
      vid_i.cs_sel = k[0];
      tick(3);
      chk(plane_pix_o, p[7:4] & b[3:0]);
      chk(colour_o, {h[3:2], k[0] ? h[1:0] : p[5:4], p[3:0]});
    end
    done("colour path");
    vid_i.mode_256 = 1'b1;
    p = $random(seed);
    vid_i.pix256 = p;
    for (k = 0; k < 4; k++) begin
      attr_wr(`ATP_IDX_PLANE, {2'b00, 2'(k), 4'hf});
      tick(2);
      rdx(k[0] ? `ATP_PORT_STAT1_MONO : `ATP_PORT_STAT1_COL,
          {2'b00, stat_exp(2'(k), p), 4'h0});
    end
    done("status mux");
    idx = $random(seed);
    i_host.wr(`ATP_PORT_WPTR, idx);
    chk(dac_drive_o, 2'b11);
    rdx(`ATP_PORT_RPTR, 8'h00);
    for (i = 0; i < 9; i++) begin
      if (i == 6) begin
        rdx(`ATP_PORT_WPTR, idx + 8'h02);
        rdx(`ATP_PORT_DATA, 8'h00);
        i_host.wr(`ATP_PORT_DATA, 8'hee);
        i_host.wr(`ATP_PORT_WPTR, idx + 8'h02);
      end
      pal[i] = $random(seed);
      i_host.wr(`ATP_PORT_DATA, pal[i]);
    end
    chk(dac_drive_o, 2'b01);
    i_host.wr(`ATP_PORT_RPTR, idx);
    chk(dac_drive_o, 2'b11);
    rdx(`ATP_PORT_RPTR, 8'h03);
    i_host.wr(`ATP_PORT_DATA, 8'h55);
    chk(dac_drive_o, 2'b01);
    for (i = 0; i < 9; i++) rdx(`ATP_PORT_DATA, pal[i]);
    chk(dac_drive_o, 2'b01);
    done("palette port");
    b = $random(seed);
    b = b & ~idx;
    i_host.wr(`ATP_PORT_MASK, ~b);
    rdx(`ATP_PORT_MASK, ~b);
    ce_i = 1'b0;
    i_host.wr(`ATP_PORT_MASK, b);
    ce_i = 1'b1;
    rdx(`ATP_PORT_MASK, ~b);
    vid_i.pix256 = idx | b;
    tick(6);
    chk(rgb_o, {pal[0], pal[1], pal[2]});
    stat_skip();
    i_host.wr(`ATP_PORT_ATTR_WR, 8'h11);
    tick(6);
    chk(video_blank_o, 1'b1);
    chk(rgb_o, 24'h0);
    done("lookup and blanking");
    tick(4);
    chk(24'(exp_q.size()), 24'h0);
    end_of_test;
  end
endmodule : attribute_tail_and_palette_dac_port_tb

`default_nettype wire
